// [hw/jsc_pkg.sv]
// Constants, codes and state types shared by the scan chain select port logic.
// Operation
// - Instruction held in 4-bit register, changed only through serial test port.
// - Instruction shift state routes instruction register between test input and output.
// - Instruction update copies shifted value into the active instruction.
// - Instruction capture loads 0001 into the instruction shift register.
// - Test logic reset makes identification-code instruction active.
// - Instruction register shifts least significant bit first, in and out.
// - 4-bit chain select register is the data path only under code 0010.
// - Data capture under chain-select loads 1000, shifted out as new number enters.
// - Data update under chain-select makes shifted number the active chain.
// - Active chain changes only by chain-select update or reset; reset selects 0.
// - Chain select register shifts least significant bit first both ways.
// - Active chain number is driven on a 4-bit output bus.
// - Chain 3 or unassigned numbers route serial data through the external chain.
// - Chains: 0 core test, 1 debug, 2 debug logic, 3 external, 4/8 reserved.
// - Scan chain 0 has 113 cells; scan chain 1 has 33 cells.
// - Input cells capture core-side input; mux feeds core system or shift data.
// - Output cells capture core output; mux drives system core or shift data.
// - Internal test applies scanned data to core, captures core outputs.
// - External test drives scanned data outward, captures system inputs.
// - System mode leaves cells idle and passes signals straight through.
// - Chain 0 internal test clocks the core once per idle cycle.
// - Chain 0 external test presents data at update, never clocks core.
// - Identification code 1110, bypass 1111, unused codes act as bypass.
// - Internal test uses code 1100 and connects the selected chain.
package jsc_pkg;
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_SCAN_SELECT = 4'h2;
    localparam logic [3:0] INSTR_INTEST = 4'hc;
    localparam logic [3:0] INSTR_IDCODE = 4'he;
    localparam logic [3:0] INSTR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
    localparam logic [3:0] CS_CAPTURE_VALUE = 4'h8;
    localparam logic [3:0] CHAIN_RESET = 4'h0;
    localparam logic [3:0] CHAIN_CORE = 4'h0;
    localparam logic [3:0] CHAIN_DEBUG = 4'h1;
    localparam logic [3:0] CHAIN_DEBUG_LOGIC = 4'h2;
    localparam logic [3:0] CHAIN_RESERVED_A = 4'h4;
    localparam logic [3:0] CHAIN_RESERVED_B = 4'h8;
    localparam int CH0_LEN = 113;
    localparam int CH0_IN_CELLS = 64;
    localparam int CH0_OUT_CELLS = CH0_LEN - CH0_IN_CELLS;
    localparam int CH1_LEN = 33;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jsc_tap_type;

    // All state clocked by the test clock.
    typedef struct packed {
        logic rst_meta;
        logic rst;
        jsc_tap_type tap;
        logic [3:0] ir_sh;
        logic [3:0] instr;
        logic [3:0] cs_sh;
        logic [3:0] chain;
        logic byp;
        logic [CH0_LEN-1:0] sh0;
        logic [CH0_LEN-1:0] upd0;
        logic [CH1_LEN-1:0] sh1;
        logic [CH1_LEN-1:0] upd1;
        logic [7:0] xfer_word;
        logic xfer_tgl;
    } jsc_tck_state_type;

    // All state clocked by the system clock.
    typedef struct packed {
        logic [2:0] tgl_sync;
        logic [3:0] chain;
        logic [3:0] instr;
    } jsc_sys_state_type;
endpackage

// [hw/jsc_scan_select.sv]
// Test access port with instruction, chain select and internal scan chains 0 and 1.
`timescale 1ns/1ps
`default_nettype none
module jsc_scan_select
    import jsc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_EN,
    output logic EXT_CHAIN_SERIAL_OUT,
    input wire logic EXT_CHAIN_SERIAL_IN,
    output logic [3:0] ACTIVE_CHAIN_NUMBER,
    output logic [3:0] CURRENT_INSTR_BUS,
    output logic [3:0] PORT_STATE_BUS,
    output logic CORE_STEP,
    input wire logic [CH0_IN_CELLS-1:0] SYS_IN0,
    output logic [CH0_IN_CELLS-1:0] CORE_IN0,
    input wire logic [CH0_OUT_CELLS-1:0] CORE_OUT0,
    output logic [CH0_OUT_CELLS-1:0] SYS_OUT0,
    input wire logic [CH1_LEN-1:0] SYS_IN1,
    output logic [CH1_LEN-1:0] CORE_IN1,
    output logic [3:0] SYS_ACTIVE_CHAIN,
    output logic [3:0] SYS_CURRENT_INSTR
);
    jsc_tck_state_type q;
    jsc_tck_state_type next_q;
    jsc_sys_state_type s;
    jsc_sys_state_type next_s;

    logic tck_rst;
    logic ext_sel;
    logic chain_instr;
    logic intest0;
    logic extest0;
    logic intest1;
    logic extest1;

    // Standard port controller transition on mode select.
    function automatic jsc_tap_type tap_next(input jsc_tap_type st, input logic m);
        jsc_tap_type n;
        n = st;
        case (st)
            TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: n = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: n = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: n = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: n = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
            default: n = TAP_RESET;
        endcase
        return n;
    endfunction

    // A chain is external when it is 3 or any number the core does not own.
    function automatic logic is_external(input logic [3:0] c);
        return !(c == CHAIN_CORE || c == CHAIN_DEBUG || c == CHAIN_DEBUG_LOGIC ||
                 c == CHAIN_RESERVED_A || c == CHAIN_RESERVED_B);
    endfunction

    // Mode decode; unused codes fall through to the bypass bit.
    assign tck_rst = q.rst;
    assign chain_instr = (q.instr == INSTR_INTEST) || (q.instr == INSTR_EXTEST);
    assign ext_sel = is_external(q.chain);
    assign intest0 = (q.instr == INSTR_INTEST) && (q.chain == CHAIN_CORE);
    assign extest0 = (q.instr == INSTR_EXTEST) && (q.chain == CHAIN_CORE);
    assign intest1 = (q.instr == INSTR_INTEST) && (q.chain == CHAIN_DEBUG);
    assign extest1 = (q.instr == INSTR_EXTEST) && (q.chain == CHAIN_DEBUG);

    // Cell multiplexers; outside a test mode the cells are transparent.
    assign CORE_IN0 = intest0 ? q.upd0[CH0_IN_CELLS-1:0] : SYS_IN0;
    assign SYS_OUT0 = extest0 ? q.upd0[CH0_LEN-1:CH0_IN_CELLS] : CORE_OUT0;
    assign CORE_IN1 = intest1 ? q.upd1 : SYS_IN1;

    // The core is stepped only while idling with chain 0 under internal test.
    assign CORE_STEP = intest0 && (q.tap == TAP_IDLE);

    // Observation buses for external chain control.
    assign ACTIVE_CHAIN_NUMBER = q.chain;
    assign CURRENT_INSTR_BUS = q.instr;
    assign PORT_STATE_BUS = 4'(q.tap);
    assign EXT_CHAIN_SERIAL_OUT = chain_instr && ext_sel && (q.tap == TAP_SHIFT_DR) && TDI;

    // Serial output select; each register path presents its least significant bit, the external chain path presents EXT_CHAIN_SERIAL_IN.
    always_comb begin
        TDO = 1'b0;
        TDO_EN = 1'b0;
        if (q.tap == TAP_SHIFT_IR) begin
            TDO = q.ir_sh[0];
            TDO_EN = 1'b1;
        end else if (q.tap == TAP_SHIFT_DR) begin
            TDO_EN = 1'b1;
            if (q.instr == INSTR_SCAN_SELECT) begin
                TDO = q.cs_sh[0];
            end else if (chain_instr && q.chain == CHAIN_CORE) begin
                TDO = q.sh0[0];
            end else if (chain_instr && q.chain == CHAIN_DEBUG) begin
                TDO = q.sh1[0];
            end else if (chain_instr && ext_sel) begin
                TDO = EXT_CHAIN_SERIAL_IN;
            end else begin
                TDO = q.byp;
            end
        end
    end

    // Test clock domain next state.
    always_comb begin
        next_q = q;
        next_q.rst_meta = RST;
        next_q.rst = q.rst_meta;
        if (q.rst) begin
            next_q.tap = TAP_RESET;
            next_q.ir_sh = IR_CAPTURE_VALUE;
            next_q.instr = INSTR_IDCODE;
            next_q.cs_sh = CS_CAPTURE_VALUE;
            next_q.chain = CHAIN_RESET;
            next_q.byp = 1'b0;
            next_q.sh0 = '0;
            next_q.upd0 = '0;
            next_q.sh1 = '0;
            next_q.upd1 = '0;
            next_q.xfer_word = {INSTR_IDCODE, CHAIN_RESET};
            next_q.xfer_tgl = 1'b0;
        end else begin
            next_q.tap = tap_next(q.tap, TMS);
            case (q.tap)
                TAP_RESET: begin
                    next_q.instr = INSTR_IDCODE;
                    next_q.chain = CHAIN_RESET;
                end
                TAP_CAP_IR: begin
                    next_q.ir_sh = IR_CAPTURE_VALUE;
                end
                TAP_SHIFT_IR: begin
                    next_q.ir_sh = {TDI, q.ir_sh[3:1]};
                end
                TAP_UPD_IR: begin
                    next_q.instr = q.ir_sh;
                end
                TAP_CAP_DR: begin
                    next_q.byp = 1'b0;
                    if (q.instr == INSTR_SCAN_SELECT) begin
                        next_q.cs_sh = CS_CAPTURE_VALUE;
                    end
                    // Input cells see the mux output, so external test grabs system pins.
                    if (chain_instr && q.chain == CHAIN_CORE) begin
                        next_q.sh0 = {CORE_OUT0, CORE_IN0};
                    end
                    if (chain_instr && q.chain == CHAIN_DEBUG) begin
                        next_q.sh1 = CORE_IN1;
                    end
                end
                TAP_SHIFT_DR: begin
                    next_q.byp = TDI;
                    if (q.instr == INSTR_SCAN_SELECT) begin
                        next_q.cs_sh = {TDI, q.cs_sh[3:1]};
                    end
                    if (chain_instr && q.chain == CHAIN_CORE) begin
                        next_q.sh0 = {TDI, q.sh0[CH0_LEN-1:1]};
                    end
                    if (chain_instr && q.chain == CHAIN_DEBUG) begin
                        next_q.sh1 = {TDI, q.sh1[CH1_LEN-1:1]};
                    end
                end
                TAP_UPD_DR: begin
                    if (q.instr == INSTR_SCAN_SELECT) begin
                        next_q.chain = q.cs_sh;
                    end
                    // Update stage keeps applied values still while new data shifts.
                    if (chain_instr && q.chain == CHAIN_CORE) begin
                        next_q.upd0 = q.sh0;
                    end
                    if (chain_instr && q.chain == CHAIN_DEBUG) begin
                        next_q.upd1 = q.sh1;
                    end
                end
                default: begin
                end
            endcase
            // Publish the values this edge installs, with a toggle for the system clock.
            // Looking at next values matters: the host may stop the test clock right after.
            if (q.xfer_word != {next_q.instr, next_q.chain}) begin
                next_q.xfer_word = {next_q.instr, next_q.chain};
                next_q.xfer_tgl = !q.xfer_tgl;
            end
        end
    end

    always_ff @(posedge TCK) begin
        q <= next_q;
    end

    // System clock domain: the word is stable once the toggle arrives.
    always_comb begin
        next_s = s;
        next_s.tgl_sync = {s.tgl_sync[1:0], q.xfer_tgl};
        if (RST) begin
            next_s.chain = CHAIN_RESET;
            next_s.instr = INSTR_IDCODE;
        end else if (s.tgl_sync[2] != s.tgl_sync[1]) begin
            next_s.instr = q.xfer_word[7:4];
            next_s.chain = q.xfer_word[3:0];
        end
    end

    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    assign SYS_ACTIVE_CHAIN = s.chain;
    assign SYS_CURRENT_INSTR = s.instr;

    // Checks on the test clock domain.
    AST_IR_CAPTURE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_CAP_IR |=> q.ir_sh == IR_CAPTURE_VALUE)
    else $error("Instruction capture did not load 0001.");

    AST_IR_UPDATE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_UPD_IR |=> q.instr == $past(q.ir_sh))
    else $error("Instruction update did not take the shifted value.");

    AST_RESET_IDCODE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_RESET |=> q.instr == INSTR_IDCODE && q.chain == CHAIN_RESET)
    else $error("Test logic reset did not restore instruction and chain.");

    AST_IR_LSB_FIRST:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_SHIFT_IR |-> TDO == q.ir_sh[0] && TDO_EN ##1 q.ir_sh[3] == $past(TDI))
    else $error("Instruction register is not shifting low bit first.");

    AST_CS_CAPTURE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_CAP_DR && q.instr == INSTR_SCAN_SELECT |=> q.cs_sh == CS_CAPTURE_VALUE)
    else $error("Chain select capture did not load 1000.");

    AST_CHAIN_HOLD:
    assert property (@(posedge TCK) disable iff (tck_rst)
        !(q.tap == TAP_UPD_DR && q.instr == INSTR_SCAN_SELECT) && q.tap != TAP_RESET
        |=> $stable(q.chain))
    else $error("Active chain moved without a chain select update.");

    AST_CHAIN_UPDATE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_UPD_DR && q.instr == INSTR_SCAN_SELECT |=> ACTIVE_CHAIN_NUMBER == $past(q.cs_sh))
    else $error("Chain select update did not reach the chain output.");

    AST_EXT_ROUTE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_SHIFT_DR && chain_instr && ext_sel
        |-> TDO == EXT_CHAIN_SERIAL_IN && EXT_CHAIN_SERIAL_OUT == TDI)
    else $error("External chain is not in the serial path.");

    AST_CORE_STEP:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_UPD_DR && intest0 && !TMS |=> CORE_STEP)
    else $error("Core step is missing in idle under chain 0 internal test.");

    AST_EXTEST_DRIVE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_UPD_DR && extest0 |=> SYS_OUT0 == $past(q.sh0[CH0_LEN-1:CH0_IN_CELLS]))
    else $error("External test did not present updated data to the system.");

    AST_SYSTEM_PASS:
    assert property (@(posedge TCK) disable iff (tck_rst)
        !chain_instr |-> CORE_IN0 == SYS_IN0 && SYS_OUT0 == CORE_OUT0 && CORE_IN1 == SYS_IN1)
    else $error("System mode is not transparent.");

    // Checks on holding registers and serial paths.
    AST_IR_HOLD:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap != TAP_CAP_IR && q.tap != TAP_SHIFT_IR |=> $stable(q.ir_sh))
    else $error("Instruction shift register moved outside capture and shift.");

    AST_INSTR_HOLD:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap != TAP_UPD_IR && q.tap != TAP_RESET |=> $stable(q.instr))
    else $error("Active instruction moved without an update.");

    AST_TDO_QUIET:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap != TAP_SHIFT_IR && q.tap != TAP_SHIFT_DR |-> !TDO_EN && !TDO)
    else $error("Serial output is active outside the shift states.");

    AST_CS_SHIFT:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_SHIFT_DR && q.instr == INSTR_SCAN_SELECT
        |-> TDO == q.cs_sh[0] ##1 q.cs_sh[3] == $past(TDI))
    else $error("Chain select register is not shifting low bit first.");

    AST_CS_HOLD:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.instr != INSTR_SCAN_SELECT |=> $stable(q.cs_sh))
    else $error("Chain select register moved under another instruction.");

    AST_BYPASS_CAPTURE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_CAP_DR |=> !q.byp)
    else $error("Bypass bit did not capture zero.");

    AST_BYPASS_PATH:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_SHIFT_DR && !chain_instr && q.instr != INSTR_SCAN_SELECT
        |-> TDO == q.byp)
    else $error("Bypass bit is not the serial path.");

    AST_EXT_IDLE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        !(q.tap == TAP_SHIFT_DR && chain_instr && ext_sel) |-> !EXT_CHAIN_SERIAL_OUT)
    else $error("External chain output is active while unused.");

    // Checks on the scan cells and the core step.
    AST_CH0_SHIFT:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_SHIFT_DR && chain_instr && q.chain == CHAIN_CORE |-> TDO == q.sh0[0]
        ##1 q.sh0[CH0_LEN-1] == $past(TDI))
    else $error("Chain 0 is not shifting through its full length.");

    AST_CH1_SHIFT:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_SHIFT_DR && chain_instr && q.chain == CHAIN_DEBUG |-> TDO == q.sh1[0]
        ##1 q.sh1[CH1_LEN-1] == $past(TDI))
    else $error("Chain 1 is not shifting through its full length.");

    AST_CORE_CAPTURE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_CAP_DR && intest0 |=> q.sh0[CH0_LEN-1:CH0_IN_CELLS] == $past(CORE_OUT0))
    else $error("Output cells did not capture the core outputs.");

    AST_EXTEST_CAPTURE:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_CAP_DR && extest0 |=> q.sh0[CH0_IN_CELLS-1:0] == $past(SYS_IN0))
    else $error("Input cells did not capture the system inputs.");

    AST_INTEST_APPLY:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_UPD_DR && intest0 |=> CORE_IN0 == $past(q.sh0[CH0_IN_CELLS-1:0]))
    else $error("Internal test did not apply chain 0 data to the core.");

    AST_INTEST1_APPLY:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap == TAP_UPD_DR && intest1 |=> CORE_IN1 == $past(q.sh1))
    else $error("Internal test did not apply chain 1 data to the core.");

    AST_CORE_STILL:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.tap != TAP_IDLE |-> !CORE_STEP)
    else $error("Core stepped outside idle.");

    AST_EXTEST_NO_STEP:
    assert property (@(posedge TCK) disable iff (tck_rst)
        q.instr != INSTR_INTEST |-> !CORE_STEP)
    else $error("Core stepped without internal test.");

    // Check on the copy kept on the system clock.
    AST_SYS_COPY:
    assert property (@(posedge CLK) disable iff (RST)
        s.tgl_sync[2] != s.tgl_sync[1] |=> SYS_ACTIVE_CHAIN == $past(q.xfer_word[3:0]))
    else $error("System copy of the chain did not follow the toggle.");
endmodule
`default_nettype wire

// [verif/jsc_host.sv]
// Behavioural test host that drives the serial test port of the scan select logic.
`timescale 1ns/1ps
`default_nettype none
module jsc_host (
    output logic TCK,
    output logic TMS,
    output logic TDI,
    input wire logic TDO
);
    // The clock stands low between steps because the host only clocks inside frames.
    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b0;
    end

    // One test clock; the return bit is read just before the rising edge shifts it away.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        TMS = tms;
        TDI = tdi;
        #6;
        tdo = TDO;
        TCK = 1'b1;
        #6;
        TCK = 1'b0;
    endtask

    // Repeats one mode select level, used for reset and idle.
    task automatic run(input int n, input logic tms);
        logic d;
        repeat (n) step(tms, 1'b0, d);
    endtask

    // Scans a register from idle back to idle, ending on the step that enters idle with no clock spent there.
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b0, d);
        if (ir) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
endmodule
`default_nettype wire

// [verif/test_jtag_scan_chain_select.sv]
// Self-checking testbench for the scan chain select port logic.
`timescale 1ns/1ps
`default_nettype none
module test_jtag_scan_chain_select;
    import jsc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_en, ext_out, core_step;
    logic ext_q = 1'b0;
    logic [3:0] chain, instr, pstate, sys_chain, sys_instr;
    logic [CH0_IN_CELLS-1:0] sys_in0 = '0;
    logic [CH0_IN_CELLS-1:0] core_in0;
    logic [CH0_OUT_CELLS-1:0] core_out0 = '0;
    logic [CH0_OUT_CELLS-1:0] sys_out0;
    logic [CH1_LEN-1:0] sys_in1 = '0;
    logic [CH1_LEN-1:0] core_in1;
    logic [127:0] o;
    logic [127:0] d = {4{32'h9e3c_51a7}};
    int err_count = 0;
    int checked = 0;

    always #5 clk = ~clk;

    // A one-cell external chain, so its data returns one test clock later.
    always @(posedge tck) ext_q <= ext_out;

    jsc_host host (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo));

    jsc_scan_select DUT (.CLK(clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_EN(tdo_en), .EXT_CHAIN_SERIAL_OUT(ext_out), .EXT_CHAIN_SERIAL_IN(ext_q),
        .ACTIVE_CHAIN_NUMBER(chain), .CURRENT_INSTR_BUS(instr), .PORT_STATE_BUS(pstate),
        .CORE_STEP(core_step), .SYS_IN0(sys_in0), .CORE_IN0(core_in0),
        .CORE_OUT0(core_out0), .SYS_OUT0(sys_out0), .SYS_IN1(sys_in1),
        .CORE_IN1(core_in1), .SYS_ACTIVE_CHAIN(sys_chain), .SYS_CURRENT_INSTR(sys_instr));

    // Compares any result, zero-extended to the widest register.
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Loads an instruction, then checks the capture pattern and the new instruction.
    task automatic load_ir(input logic [3:0] code);
        host.scan(1'b1, 4, code, o);
        cmp(o[3:0], IR_CAPTURE_VALUE);
        cmp(instr, code);
    endtask

    task automatic select_chain(input logic [3:0] ch);
        load_ir(INSTR_SCAN_SELECT);
        host.scan(1'b0, 4, ch, o);
        cmp(o[3:0], CS_CAPTURE_VALUE);
        cmp(chain, ch);
        repeat (10) @(posedge clk);
        cmp(sys_chain, ch);
    endtask

    task automatic t_reset;
        cmp(instr, INSTR_IDCODE);
        cmp(chain, CHAIN_RESET);
        cmp(pstate, 4'h1);
        cmp(tdo_en, 1'b0);
    endtask

    // Unused code 5, identification and bypass all give a one-bit path that captures 0.
    task automatic t_bypass;
        logic [3:0] codes [3] = '{INSTR_BYPASS, INSTR_IDCODE, 4'h5};
        foreach (codes[i]) begin
            load_ir(codes[i]);
            host.scan(1'b0, 3, 3'b011, o);
            cmp(o[2:0], 3'b110);
            cmp(core_in0, sys_in0);
            cmp(sys_out0, core_out0);
            cmp(core_in1, sys_in1);
        end
    endtask

    // Chain 3 routes the data through the external cell and back.
    task automatic t_external;
        select_chain(4'h3);
        load_ir(INSTR_INTEST);
        host.scan(1'b0, 9, 8'ha5, o);
        cmp(o[8:1], 8'ha5);
        cmp(chain, 4'h3);
    endtask

    task automatic t_intest0;
        select_chain(CHAIN_CORE);
        load_ir(INSTR_INTEST);
        host.scan(1'b0, CH0_LEN, d, o);
        cmp(o[112:64], core_out0);
        cmp(core_in0, d[63:0]);
        cmp(core_step, 1'b1);
        host.scan(1'b0, CH0_LEN, ~d, o);
        cmp(o[63:0], d[63:0]);
        cmp(chain, CHAIN_CORE);
    endtask

    task automatic t_extest0;
        load_ir(INSTR_EXTEST);
        host.scan(1'b0, CH0_LEN, d, o);
        cmp(o[63:0], sys_in0);
        cmp(sys_out0, d[112:64]);
        cmp(core_step, 1'b0);
        repeat (10) @(posedge clk);
        cmp(sys_instr, INSTR_EXTEST);
    endtask

    task automatic t_chain1;
        select_chain(CHAIN_DEBUG);
        load_ir(INSTR_INTEST);
        host.scan(1'b0, CH1_LEN, d, o);
        cmp(core_in1, d[32:0]);
        cmp(core_step, 1'b0);
        host.scan(1'b0, CH1_LEN, ~d, o);
        cmp(o[32:0], d[32:0]);
    endtask

    // Five high mode selects reach test logic reset from anywhere.
    task automatic t_tlr;
        host.run(5, 1'b1);
        cmp(instr, INSTR_IDCODE);
        cmp(chain, CHAIN_RESET);
        cmp(pstate, 4'h0);
        host.run(1, 1'b0);
        repeat (10) @(posedge clk);
        cmp(sys_chain, CHAIN_RESET);
        cmp(sys_instr, INSTR_IDCODE);
    endtask

    // Hang guard: running out of time counts as a mismatch.
    initial begin
        #300000;
        err_count++;
        end_sim();
    end

    // Main sequence; the test clock runs while reset is held.
    initial begin
        fork
            host.run(8, 1'b1);
            repeat (20) @(posedge clk);
        join
        rst <= 1'b0;
        host.run(4, 1'b1);
        host.run(1, 1'b0);
        @(posedge clk);
        sys_in0 <= 64'h0123_4567_89ab_cdef;
        core_out0 <= 49'h1_5a3c_0f96_e1d2;
        sys_in1 <= 33'h1_2345_6789;
        repeat (2) @(posedge clk);
        t_reset();
        t_bypass();
        t_external();
        t_intest0();
        t_extest0();
        t_chain1();
        t_tlr();
        end_sim();
    end
endmodule
`default_nettype wire
